// ### src/pwm_timer_pkg.sv
// Package with register map, field layouts and types of the 24-bit PWM capture timer.
package pwm_timer_pkg;

   localparam int CNT_W   = 24;
   localparam int PRE_W   = 8;
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 32;
   localparam int NUM_IRQ = 5;

   // Register byte offsets.
   localparam logic [ADDR_W-1:0] CTRL_OFS    = 8'h00;
   localparam logic [ADDR_W-1:0] PRESCALE_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] COUNT_OFS   = 8'h08;
   localparam logic [ADDR_W-1:0] CMP0_OFS    = 8'h0C;
   localparam logic [ADDR_W-1:0] CMP1_OFS    = 8'h10;
   localparam logic [ADDR_W-1:0] CAP0_OFS    = 8'h14;
   localparam logic [ADDR_W-1:0] CAP1_OFS    = 8'h18;
   localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h1C;
   localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h20;
   localparam logic [ADDR_W-1:0] PIN_OFS     = 8'h24;

   // Interrupt bit positions.
   localparam int IRQ_OVF  = 0;
   localparam int IRQ_CAP0 = 1;
   localparam int IRQ_CAP1 = 2;
   localparam int IRQ_CMP0 = 3;
   localparam int IRQ_CMP1 = 4;

   // Edge selection for a capture input.
   typedef enum logic [1:0] {
      EDGE_OFF  = 2'h0,
      EDGE_RISE = 2'h1,
      EDGE_FALL = 2'h2,
      EDGE_BOTH = 2'h3
   } edge_sel_type;

   // Counter clear source.
   typedef enum logic [1:0] {
      CLR_ROLLOVER = 2'h0,
      CLR_CMP0     = 2'h1,
      CLR_CMP1     = 2'h2,
      CLR_NONE     = 2'h3
   } clr_sel_type;

   // Output pin action on the second compare event.
   typedef enum logic [1:0] {
      ACT_NONE   = 2'h0,
      ACT_SET    = 2'h1,
      ACT_CLEAR  = 2'h2,
      ACT_TOGGLE = 2'h3
   } pin_act_type;

   // Shadow transfer mode.
   typedef enum logic {
      UPD_IMMEDIATE = 1'b0,
      UPD_ON_MATCH  = 1'b1
   } upd_mode_type;

   // Control register layout, high bits first, last field bit 0 = run.
   typedef struct packed {
      logic          gpio_mode;   // [12]
      upd_mode_type  upd_mode;    // [11]
      pin_act_type   pin_act;     // [10:9]
      clr_sel_type   clr_sel;     // [8:7]
      edge_sel_type  edge1;       // [6:5]
      edge_sel_type  edge0;       // [4:3]
      logic          sw_clear;    // [2]
      logic          pin_init;    // [1]
      logic          run;         // [0]
   } ctrl_type;

   localparam int CTRL_W = $bits(ctrl_type);
   localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;
   localparam int CTRL_SWCLR_BIT = 2;
   localparam logic [PRE_W-1:0] PRESCALE_RST = 8'h00;
   localparam logic [CNT_W-1:0] CNT_MAX = 24'hFF_FFFF;
   localparam logic [DATA_W-1:0] BAD_ADDR_DATA = 32'h0000_0000;

   // APB request bundle.
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } apb_req_type;

endpackage

// ### src/capture_edge.sv
// Capture input synchroniser, edge detector and capture data register.
`timescale 1ns/1ps
module capture_edge
   import pwm_timer_pkg::*;
#(
   parameter int WIDTH = 24
) (
   input  wire logic             core_clk_i,
   input  wire logic             resetn_i,
   input  wire logic             pin_i,
   input  wire edge_sel_type     edge_sel_i,
   input  wire logic [WIDTH-1:0] count_i,
   output logic                  event_o,
   output logic [WIDTH-1:0]      cap_o
);

   logic sync1_r;
   logic sync2_r;
   logic prev_r;
   logic rise;
   logic fall;
   logic hit;

   // Two-flop synchroniser, then a history flop for edge detection.
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r  <= 1'b0;
      end else begin
         sync1_r <= pin_i;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   assign rise = sync2_r & ~prev_r;
   assign fall = ~sync2_r & prev_r;
   // Edge qualification per selected condition.
   assign hit = ((edge_sel_i == EDGE_RISE) && rise) ||
                ((edge_sel_i == EDGE_FALL) && fall) ||
                ((edge_sel_i == EDGE_BOTH) && (rise || fall));

   // Latch the counter on a qualified edge.
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         cap_o   <= '0;
         event_o <= 1'b0;
      end else begin
         event_o <= hit;
         if (hit) begin
            cap_o <= count_i;
         end
      end
   end

endmodule

// ### src/pwm_timer_24bit_capture.sv
// 24-bit PWM timer with prescaler, shadowed compares, two captures, APB slave and interrupt.
//
// Behaviour
// - One 24-bit up-counter advances once per tick of an 8-bit programmable prescaler on the bus clock.
// - Two compare registers are compared with the counter and equality gives a compare event.
// - Compare writes go to a shadow buffer and reach the active compare at once, or after a match in on-match mode while running.
// - Each capture input detects rising, falling or both edges as selected.
// - A capture event copies the counter into that input's capture data register.
// - The counter clears on rollover, on a compare-equal event, or on a firmware clear request.
// - Overflow, capture zero, capture one and both compare matches are five separately enabled interrupts.
// - Only the second compare event drives the output pin: set, clear, toggle or no action.
// - The first compare event never changes the output pin, it raises its interrupt and, when selected as clear source, clears the counter.
// - The output pin level is readable, and the pin can instead be a general input read by firmware.
`timescale 1ns/1ps
module pwm_timer_24bit_capture
   import pwm_timer_pkg::*;
#(
   parameter int COUNT_WIDTH = CNT_W,
   parameter int PRE_WIDTH   = PRE_W
) (
   input  wire logic              core_clk_i,
   input  wire logic              resetn_i,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [ADDR_W-1:0] paddr_i,
   input  wire logic [DATA_W-1:0] pwdata_i,
   output logic [DATA_W-1:0]      prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   input  wire logic              capture_input_zero_i,
   input  wire logic              capture_input_one_i,
   input  wire logic              timer_output_pin_i,
   output logic                   timer_output_pin_o,
   output logic                   timer_output_pin_oe_o,
   output logic                   irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.

   // Bus request and the control word that a write carries.
   apb_req_type                req;
   ctrl_type                   wr_ctrl;

   // Configuration and time base.
   ctrl_type                   ctrl_r;
   logic [PRE_WIDTH-1:0]       prescale_r;
   logic [PRE_WIDTH-1:0]       pre_cnt_r;
   logic [COUNT_WIDTH-1:0]     count_r;

   // Active compares, shadows and pending transfers.
   logic [COUNT_WIDTH-1:0]     cmp0_r;
   logic [COUNT_WIDTH-1:0]     cmp1_r;
   logic [COUNT_WIDTH-1:0]     shadow0_r;
   logic [COUNT_WIDTH-1:0]     shadow1_r;
   logic                       pend0_r;
   logic                       pend1_r;

   // Capture channel results.
   logic [COUNT_WIDTH-1:0]     cap0;
   logic [COUNT_WIDTH-1:0]     cap1;
   logic                       cap0_evt;
   logic                       cap1_evt;

   // Interrupt status, mask and events.
   logic [NUM_IRQ-1:0]         stat_r;
   logic [NUM_IRQ-1:0]         mask_r;
   logic [NUM_IRQ-1:0]         evt;

   // Pin state and readback flops.
   logic                       pin_r;
   logic                       pin_sync1_r;
   logic                       pin_sync2_r;

   // Strobes of the time base.
   logic                       swclr_r;
   logic                       tick;
   logic                       at_max;
   logic                       match0;
   logic                       match1;
   logic                       clr_hit;

   // Bus strobes and read path.
   logic                       wr_en;
   logic                       rd_en;
   logic                       addr_ok;
   logic [DATA_W-1:0]          rd_mux;

   ////////////////////////////////////////////////////////////////////////////
   // APB decode; the slave answers in the first access cycle.


   assign req = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i, paddr: paddr_i, pwdata: pwdata_i};
   // Write data seen as a control word.
   assign wr_ctrl = ctrl_type'(req.pwdata[CTRL_W-1:0]);
   assign wr_en = req.psel && req.penable && req.pwrite;
   assign rd_en = req.psel && !req.penable && !req.pwrite;

   // Address validity check for the register map.
   always_comb begin
      case (req.paddr)
         CTRL_OFS, PRESCALE_OFS, COUNT_OFS, CMP0_OFS, CMP1_OFS,
         CAP0_OFS, CAP1_OFS, IRQ_STAT_OFS, IRQ_MASK_OFS, PIN_OFS: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // Read multiplexer, narrow registers sit in the low bits.
   always_comb begin
      case (req.paddr)
         CTRL_OFS:     rd_mux = DATA_W'(ctrl_r);
         PRESCALE_OFS: rd_mux = DATA_W'(prescale_r);
         COUNT_OFS:    rd_mux = DATA_W'(count_r);
         CMP0_OFS:     rd_mux = DATA_W'(shadow0_r);
         CMP1_OFS:     rd_mux = DATA_W'(shadow1_r);
         CAP0_OFS:     rd_mux = DATA_W'(cap0);
         CAP1_OFS:     rd_mux = DATA_W'(cap1);
         IRQ_STAT_OFS: rd_mux = DATA_W'(stat_r);
         IRQ_MASK_OFS: rd_mux = DATA_W'(mask_r);
         PIN_OFS:      rd_mux = DATA_W'(pin_sync2_r);
         default:      rd_mux = BAD_ADDR_DATA;
      endcase
   end

   // Answering from flops keeps bus timing short.
   // It adds no wait state, ready comes in the first access cycle.
   // Every transfer therefore takes two cycles.
   // Registered APB answer: read data captured in setup, ready in the access cycle.
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         prdata_o  <= '0;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         pready_o  <= req.psel && !req.penable;
         pslverr_o <= req.psel && !req.penable && !addr_ok;
         if (rd_en) begin
            prdata_o <= rd_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers.


   // The clear request lives only as a strobe.
   // A read of control never shows it set.
   // Control, prescaler and mask writes; the clear bit self-resets.
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         ctrl_r     <= ctrl_type'(CTRL_RST);
         prescale_r <= PRESCALE_RST;
         mask_r     <= '0;
         swclr_r    <= 1'b0;
      end else begin
         swclr_r <= wr_en && (req.paddr == CTRL_OFS) && req.pwdata[CTRL_SWCLR_BIT];
         if (wr_en && req.paddr == CTRL_OFS) begin
            ctrl_r          <= ctrl_type'(req.pwdata[CTRL_W-1:0]);
            ctrl_r.sw_clear <= 1'b0;
         end
         if (wr_en && req.paddr == PRESCALE_OFS) begin
            prescale_r <= req.pwdata[PRE_WIDTH-1:0];
         end
         if (wr_en && req.paddr == IRQ_MASK_OFS) begin
            mask_r <= req.pwdata[NUM_IRQ-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler and counter.


   assign tick    = ctrl_r.run && (pre_cnt_r == prescale_r);
   assign at_max  = (count_r == COUNT_WIDTH'(CNT_MAX));
   assign match0  = tick && (count_r == cmp0_r);
   assign match1  = tick && (count_r == cmp1_r);
   assign clr_hit = ((ctrl_r.clr_sel == CLR_CMP0) && match0) ||
                    ((ctrl_r.clr_sel == CLR_CMP1) && match1);

   // A stop or clear restarts the division.
   // The first tick after start is a full period away.
   // Prescaler divides the clock by prescale plus one.
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         pre_cnt_r <= '0;
      end else if (!ctrl_r.run || tick || swclr_r) begin
         pre_cnt_r <= '0;
      end else begin
         pre_cnt_r <= pre_cnt_r + PRE_WIDTH'(1);
      end
   end

   // The wrap at the top value is always taken.
   // A compare above the period still restarts cleanly.
   // A firmware clear beats a tick in the same cycle.
   // Counter advances per tick; compare clear or firmware clear returns it to zero.
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         count_r <= '0;
      end else if (swclr_r) begin
         count_r <= '0;
      end else if (tick) begin
         if (clr_hit || at_max) begin
            count_r <= '0;
         end else begin
            count_r <= count_r + COUNT_WIDTH'(1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shadowed compare registers.


   // A write while running in on-match mode waits for its match.
   // In on-match mode the running period is never cut short.
   // Reads return the shadow, the value last written.
   // Writes land in the shadow; transfer on match, or at once when stopped or immediate.
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         shadow0_r <= '0;
         shadow1_r <= '0;
         cmp0_r    <= '0;
         cmp1_r    <= '0;
         pend0_r   <= 1'b0;
         pend1_r   <= 1'b0;
      end else begin
         if (wr_en && req.paddr == CMP0_OFS) begin
            shadow0_r <= req.pwdata[COUNT_WIDTH-1:0];
            pend0_r   <= 1'b1;
         end else if (pend0_r && (!ctrl_r.run || ctrl_r.upd_mode == UPD_IMMEDIATE || match0)) begin
            cmp0_r  <= shadow0_r;
            pend0_r <= 1'b0;
         end
         if (wr_en && req.paddr == CMP1_OFS) begin
            shadow1_r <= req.pwdata[COUNT_WIDTH-1:0];
            pend1_r   <= 1'b1;
         end else if (pend1_r && (!ctrl_r.run || ctrl_r.upd_mode == UPD_IMMEDIATE || match1)) begin
            cmp1_r  <= shadow1_r;
            pend1_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Capture inputs.


   // Both channels latch the same counter.
   // Each has its own synchroniser.
   // A capture lands three clocks after the edge.
   // Capture channel zero.
   capture_edge #(
      .WIDTH (COUNT_WIDTH)
   ) u_cap0 (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .pin_i      (capture_input_zero_i),
      .edge_sel_i (ctrl_r.edge0),
      .count_i    (count_r),
      .event_o    (cap0_evt),
      .cap_o      (cap0)
   );

   // Capture channel one.
   capture_edge #(
      .WIDTH (COUNT_WIDTH)
   ) u_cap1 (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .pin_i      (capture_input_one_i),
      .edge_sel_i (ctrl_r.edge1),
      .count_i    (count_r),
      .event_o    (cap1_evt),
      .cap_o      (cap1)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Output pin.


   // The initial level is taken only while stopped.
   // A running waveform is never disturbed.
   // Control writes during a run leave the pin alone.
   // Second compare acts on the pin; the first compare has no path here.
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         pin_r <= 1'b0;
      end else if (wr_en && req.paddr == CTRL_OFS && !ctrl_r.run) begin
         pin_r <= wr_ctrl.pin_init; // Initial level loaded while stopped.
      end else if (match1) begin
         case (ctrl_r.pin_act)
            ACT_SET:    pin_r <= 1'b1;
            ACT_CLEAR:  pin_r <= 1'b0;
            ACT_TOGGLE: pin_r <= ~pin_r;
            default:    pin_r <= pin_r;
         endcase
      end
   end

   // The pin is outside the clock domain.
   // Drive or release the pin and synchronise its level for readback.
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         timer_output_pin_o    <= 1'b0;
         timer_output_pin_oe_o <= 1'b0;
         pin_sync1_r           <= 1'b0;
         pin_sync2_r           <= 1'b0;
      end else begin
         timer_output_pin_o    <= pin_r;
         timer_output_pin_oe_o <= !ctrl_r.gpio_mode;
         pin_sync1_r           <= timer_output_pin_i;
         pin_sync2_r           <= pin_sync1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts.


   // One-clock event strobes.
   assign evt[IRQ_OVF]  = tick && at_max;
   assign evt[IRQ_CAP0] = cap0_evt;
   assign evt[IRQ_CAP1] = cap1_evt;
   assign evt[IRQ_CMP0] = match0;
   assign evt[IRQ_CMP1] = match1;

   // The line follows the status a clock later.
   // A clear that meets an event leaves it high.
   // No event is lost to a clear.
   // Sticky status, write one to clear, a new event wins over the clear.
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         stat_r <= '0;
         irq_o  <= 1'b0;
      end else begin
         if (wr_en && req.paddr == IRQ_STAT_OFS) begin
            stat_r <= (stat_r & ~req.pwdata[NUM_IRQ-1:0]) | evt;
         end else begin
            stat_r <= stat_r | evt;
         end
         irq_o <= |(stat_r & mask_r);
      end
   end

endmodule

// ### tb/pwm_timer_assertions.sv
// Checker of bus handshake, interrupt level and pin enable at the timer ports.
`timescale 1ns/1ps
module pwm_timer_assertions
   import pwm_timer_pkg::*;
(
   input wire logic              core_clk_i,
   input wire logic              resetn_i,
   input wire logic              psel_i,
   input wire logic              penable_i,
   input wire logic              pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [DATA_W-1:0] pwdata_i,
   input wire logic [DATA_W-1:0] prdata_o,
   input wire logic              pready_o,
   input wire logic              pslverr_o,
   input wire logic              irq_o,
   input wire logic              timer_output_pin_oe_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   ////////////////////////////////////////////////////////////////////////////
   // The answer is a single pulse in the first access cycle.
   property p_rdy_one; pready_o |=> !pready_o; endproperty
   a_rdy_one: assert property (p_rdy_one) else $error("pready stays high.");
   property p_rdy_acc; psel_i && !penable_i |=> pready_o; endproperty
   a_rdy_acc: assert property (p_rdy_acc) else $error("pready missing after setup.");
   property p_rdy_qual; pready_o |-> psel_i && penable_i; endproperty
   a_rdy_qual: assert property (p_rdy_qual) else $error("pready outside access.");
   // Errors come with the answer and a refused read returns zero.
   property p_err_rdy; pslverr_o |-> pready_o && (pwrite_i || prdata_o == BAD_ADDR_DATA); endproperty
   a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready.");
   property p_err_map; psel_i && !penable_i && paddr_i > PIN_OFS |=> pslverr_o; endproperty
   a_err_map: assert property (p_err_map) else $error("unmapped address accepted.");
   property p_ok_map; psel_i && !penable_i && paddr_i <= PIN_OFS && paddr_i[1:0] == 2'h0 |=> !pslverr_o; endproperty
   a_ok_map: assert property (p_ok_map) else $error("mapped address refused.");
   // A cleared mask silences the interrupt line.
   property p_irq_mask;
      psel_i && penable_i && pwrite_i && paddr_i == IRQ_MASK_OFS && pwdata_i[4:0] == 5'h00 |-> ##2 !irq_o;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("irq high with mask cleared.");
   // The pin driver follows the input mode bit.
   property p_oe_mode;
      psel_i && penable_i && pwrite_i && paddr_i == CTRL_OFS |-> ##2 timer_output_pin_oe_o == !$past(pwdata_i[12], 2);
   endproperty
   a_oe_mode: assert property (p_oe_mode) else $error("pin enable disagrees with mode.");
   // Outputs are quiet one edge into reset.
   property p_rst;
      disable iff (1'b0) !resetn_i |=> !pready_o && !pslverr_o && !irq_o && !timer_output_pin_oe_o;
   endproperty
   a_rst: assert property (p_rst) else $error("output active in reset.");
   c_irq: cover property ($rose(irq_o));
   c_err: cover property (pslverr_o);
   c_gpio: cover property ($fell(timer_output_pin_oe_o));
endmodule
bind pwm_timer_24bit_capture pwm_timer_assertions u_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o),
   .timer_output_pin_oe_o(timer_output_pin_oe_o));

// ### tb/pin_side_model.sv
// Model of the capture sources and of the outside party on the timer pin.
`timescale 1ns/1ps
module pin_side_model (
   input  wire logic core_clk_i,
   input  wire logic pin_o_i,
   input  wire logic pin_oe_i,
   output logic      cap0_o,
   output logic      cap1_o,
   output logic      pin_w_o
);
   logic ext_lvl;
   // Capture sources idle low and the outside level starts low.
   initial begin
      cap0_o = 1'b0;
      cap1_o = 1'b0;
      ext_lvl = 1'b0;
   end
   // The wire carries the timer drive while enabled, else the outside level.
   assign pin_w_o = pin_oe_i ? pin_o_i : ext_lvl;
   // Capture levels change just after a rising edge.
   task set_caps(input logic a, input logic b);
      @(posedge core_clk_i);
      cap0_o <= a;
      cap1_o <= b;
   endtask
   // The outside party drives a new level on the pin.
   task set_ext(input logic v);
      @(posedge core_clk_i);
      ext_lvl <= v;
   endtask
endmodule

// ### tb/pwm_timer_24bit_capture_test.sv
// Self-checking bench of the PWM capture timer over APB.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module pwm_timer_24bit_capture_test;
   import pwm_timer_pkg::*;
   logic              core_clk, resetn, psel, penable, pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rdv, c0;
   logic              pready, pslverr, cap0, cap1, pin_o, pin_oe, pin_w, irq;
   logic [32:0]       exq[$], mkq[$], e_h, m_h;
   int                n_mismatch, checked, g, p, c1;
   pin_side_model m (.core_clk_i(core_clk), .pin_o_i(pin_o), .pin_oe_i(pin_oe), .cap0_o(cap0),
      .cap1_o(cap1), .pin_w_o(pin_w));
   // Counter width shortened so that a wrap is reached quickly.
   pwm_timer_24bit_capture #(.COUNT_WIDTH(8)) dut (.core_clk_i(core_clk), .resetn_i(resetn),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .capture_input_zero_i(cap0),
      .capture_input_one_i(cap1), .timer_output_pin_i(pin_w), .timer_output_pin_o(pin_o),
      .timer_output_pin_oe_o(pin_oe), .irq_o(irq));
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   // One APB transfer, held until pready is seen at a falling edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(negedge core_clk);
      while (pready !== 1'b1 && n < 20) begin @(negedge core_clk); n++; end
      if (n == 20) n_mismatch++;
      @(posedge core_clk);
      rdv = prdata;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
   // Read with an expected {pslverr, prdata} under a mask.
   task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] k);
      exq.push_back(e); mkq.push_back(k); apb(1'b0, a, 32'h0000_0000);
   endtask
   // Cycles between two changes of the pin drive, less one.
   task automatic gap(output int c);
      logic v;
      c = 0;
      @(negedge core_clk); v = pin_o;
      while (pin_o === v && c < 500) begin @(negedge core_clk); c++; end
   endtask
   function automatic logic [31:0] cw(logic r, edge_sel_type e, clr_sel_type k, pin_act_type a, logic gp);
      ctrl_type c;
      c = {gp, UPD_ON_MATCH, a, k, e, e, 1'b0, 1'b0, r};
      return 32'(c);
   endfunction
   // Each read answer is compared with the oldest noted expectation.
   always @(posedge core_clk) begin
      if (psel && penable && !pwrite && pready === 1'b1 && exq.size() > 0) begin
         e_h = exq.pop_front(); m_h = mkq.pop_front();
         `CHK({pslverr, prdata} & m_h, e_h & m_h)
      end
   end
   task finish_test;
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Watchdog well beyond the expected run length.
   initial begin
      #100000;
      n_mismatch++;
      finish_test;
   end
   initial begin
      psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0; resetn = 1'b0;
      n_mismatch = 0; checked = 0;
      void'($urandom(86646));
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      for (int a = 0; a < 10; a++) rd(8'(4 * a), 33'h0, (a == 9) ? 33'h0 : 33'h1_FFFF_FFFF);
      wr(8'h28, 32'h1234_5678);
      rd(8'h28, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
      $display("reset and map test done");
      wr(IRQ_MASK_OFS, 32'h0000_001F);
      for (int k = 0; k < 4; k++) begin
         wr(CTRL_OFS, cw(1'b0, edge_sel_type'(k), CLR_NONE, ACT_NONE, 1'b0));
         wr(IRQ_STAT_OFS, 32'h0000_001F);
         m.set_caps(1'b1, 1'b1); repeat (8) @(posedge core_clk);
         rd(IRQ_STAT_OFS, (k & 1) ? 33'h6 : 33'h0, 33'h6);
         `CHK(irq, 1'((k & 1) != 0))
         wr(IRQ_STAT_OFS, 32'h0000_0006);
         m.set_caps(1'b0, 1'b0); repeat (8) @(posedge core_clk);
         rd(IRQ_STAT_OFS, (k & 2) ? 33'h6 : 33'h0, 33'h6);
      end
      $display("capture edge test done");
      p = $urandom % 4;
      wr(PRESCALE_OFS, 32'(p));
      wr(CTRL_OFS, cw(1'b1, EDGE_RISE, CLR_NONE, ACT_NONE, 1'b0));
      m.set_caps(1'b1, 1'b0); repeat (100 * (p + 1) - 1) @(posedge core_clk);
      m.set_caps(1'b1, 1'b1); repeat (1100) @(posedge core_clk);
      rd(CAP0_OFS, 33'h0, 33'h0); c0 = rdv;
      rd(CAP1_OFS, 33'h0, 33'h0);
      `CHK(8'(rdv - c0), 8'd100)
      rd(IRQ_STAT_OFS, 33'h1, 33'h1);
      m.set_caps(1'b0, 1'b0);
      $display("prescale and capture test done");
      wr(CTRL_OFS, 32'h0000_0000); wr(PRESCALE_OFS, 32'h0000_0000); wr(CTRL_OFS, 32'h0000_0004);
      rd(COUNT_OFS, 33'h0, 33'h1_FFFF_FFFF);
      c1 = 5 + $urandom % 20;
      wr(CMP0_OFS, 32'h0000_0003); wr(CMP1_OFS, 32'(c1)); wr(IRQ_STAT_OFS, 32'h0000_001F);
      wr(CTRL_OFS, cw(1'b1, EDGE_OFF, CLR_CMP1, ACT_TOGGLE, 1'b0));
      gap(g); gap(g); `CHK(g + 1, c1 + 1)
      wr(CMP1_OFS, 32'(c1 + 10));
      rd(CMP1_OFS, 33'(c1 + 10), 33'h1_FFFF_FFFF);
      gap(g); gap(g); gap(g); `CHK(g + 1, c1 + 11)
      rd(IRQ_STAT_OFS, 33'h18, 33'h18);
      $display("compare and shadow test done");
      for (int k = 0; k < 3; k++) begin
         wr(CTRL_OFS, cw(1'b1, EDGE_OFF, CLR_CMP1, (k == 0) ? ACT_SET : (k == 1) ? ACT_NONE : ACT_CLEAR, 1'b0));
         repeat (80) @(posedge core_clk);
         `CHK(pin_o, 1'(k < 2))
         rd(PIN_OFS, 33'(k < 2), 33'h1);
      end
      wr(CTRL_OFS, cw(1'b0, EDGE_OFF, CLR_NONE, ACT_NONE, 1'b1));
      m.set_ext(1'b1); repeat (4) @(posedge core_clk);
      `CHK(pin_oe, 1'b0)
      rd(PIN_OFS, 33'h1, 33'h1);
      m.set_ext(1'b0); repeat (4) @(posedge core_clk);
      rd(PIN_OFS, 33'h0, 33'h1);
      $display("pin action and input test done");
      wr(IRQ_MASK_OFS, 32'h0000_0000); repeat (3) @(posedge core_clk);
      `CHK(irq, 1'b0)
      wr(IRQ_MASK_OFS, 32'h0000_0018); repeat (3) @(posedge core_clk);
      `CHK(irq, 1'b1)
      wr(IRQ_STAT_OFS, 32'h0000_001F); repeat (3) @(posedge core_clk);
      `CHK(irq, 1'b0)
      rd(IRQ_STAT_OFS, 33'h0, 33'h1F);
      $display("interrupt test done");
      finish_test;
   end
endmodule
